// ===== pkg/sequencer_pkg.sv
// Shared constants, carrier types and the state decoder for the measurement sequencer.
package sequencer_pkg;

  localparam int unsigned SEQ_STATE_COUNT = 16;
  localparam logic [3:0] SEQ_START_STATE = 4'h0;
  localparam logic [3:0] LAST_MEASURE_STATE = 4'h9;
  localparam logic [3:0] LONG_STEP_SET_STATE = 4'hb;
  localparam logic [3:0] LONG_STEP_END_STATE = 4'hc;
  localparam logic [3:0] RELEASE_ENTRY_STATE = 4'h8;
  localparam logic [3:0] PRINT_FIRST_STATE = 4'hd;
  localparam logic [3:0] PRINT_SECOND_STATE = 4'he;

  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned RESET_PULSE_NS = 5000;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS * CORE_CLK_MHZ) / 1000;
  localparam int unsigned RESET_COUNT_WIDTH = 10;

  typedef struct packed {
    logic [SEQ_STATE_COUNT-1:0] command_lines;
    logic data_update;
    logic print_command;
  } seq_command_type;

  typedef struct packed {
    logic [3:0] state;
    logic measure_phase;
    logic long_step;
    logic long_step_release;
  } seq_status_type;

  function automatic logic [SEQ_STATE_COUNT-1:0] decode_state(input logic [3:0] state);
    decode_state = 16'h0001 << state;
  endfunction : decode_state

endpackage : sequencer_pkg

// ===== logic/reset_pulse_generator.sv
// Retriggerable one-shot that stretches a reset trigger into a fixed-width pulse.
`timescale 1ns/1ps
`default_nettype none

module reset_pulse_generator
  import sequencer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Trigger and pulse
  input wire logic trigger,
  output logic pulse
);

  logic [RESET_COUNT_WIDTH-1:0] remaining;

  // Power-up itself counts as a reset event, so the pulse starts armed.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining <= RESET_COUNT_WIDTH'(RESET_PULSE_CYCLES - 1);
      pulse <= 1'b1;
    end else if (trigger) begin
      remaining <= RESET_COUNT_WIDTH'(RESET_PULSE_CYCLES - 1);
      pulse <= 1'b1;
    end else if (remaining != '0) begin
      remaining <= remaining - 10'h001;
    end else begin
      pulse <= 1'b0;
    end
  end

  logic [RESET_COUNT_WIDTH-1:0] high_cycles;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cycles <= '0;
    end else if (trigger || !pulse) begin
      high_cycles <= '0;
    end else begin
      high_cycles <= high_cycles + 10'h001;
    end
  end

  a_pulse_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($fell(pulse) && !$past(trigger)) |-> $past(high_cycles) == RESET_COUNT_WIDTH'(RESET_PULSE_CYCLES - 1))
    else $error("reset pulse width is wrong");

endmodule : reset_pulse_generator

`default_nettype wire

// ===== logic/measurement_sequence_generator.sv
// Sixteen-state control sequencer that steps the counter through a measurement cycle.
`timescale 1ns/1ps
`default_nettype none

module measurement_sequence_generator
  import sequencer_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sequence clock, one core cycle per pulse
  input wire logic seq_clk_pulse,
  // Step holds
  input wire logic internal_hold,
  input wire logic external_hold,
  input wire logic remote_programming_option,
  // Reset requests
  input wire logic seq_reset_req,
  input wire logic cond_reset_req,
  input wire logic hard_reset_req,
  // Commands and state
  output seq_command_type command,
  output seq_status_type status,
  // Reset pulses to the count chain and converter
  output logic count_chain_reset,
  output logic converter_reset
);

  logic [3:0] sequence_counter;
  logic measure_phase_flag;
  logic long_step_flag;
  logic long_step_release_flag;
  logic [SEQ_STATE_COUNT-1:0] command_lines;
  logic print_pulse_gate;
  logic reset_pulse;

  logic hold_active;
  logic seq_reset;
  logic step;
  logic decoder_enable;
  logic [3:0] next_state;

  reset_pulse_generator u_reset_pulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trigger(hard_reset_req),
    .pulse(reset_pulse)
  );

  assign count_chain_reset = reset_pulse;
  assign converter_reset = reset_pulse;

  assign hold_active = internal_hold | (remote_programming_option & external_hold);

  assign seq_reset = reset_pulse | seq_reset_req | (cond_reset_req & measure_phase_flag);

  assign step = seq_clk_pulse & ~seq_reset & (long_step_flag | ~hold_active);

  assign next_state = 4'(sequence_counter + 4'h1);

  assign decoder_enable = ~seq_reset & ~step & (~long_step_flag | long_step_release_flag);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sequence_counter <= SEQ_START_STATE;
    end else if (seq_reset) begin
      sequence_counter <= SEQ_START_STATE;
    end else if (step) begin
      sequence_counter <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      measure_phase_flag <= 1'b1;
    end else if (seq_reset) begin
      measure_phase_flag <= 1'b1;
    end else if (step) begin
      measure_phase_flag <= (next_state <= LAST_MEASURE_STATE);
    end
  end

  // The flags move only on a step or a sequence reset, so a frozen clock also freezes the long step.
  // long step set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      long_step_flag <= 1'b0;
      long_step_release_flag <= 1'b0;
    end else if (seq_reset) begin
      long_step_flag <= 1'b0;
      long_step_release_flag <= 1'b0;
    end else if (step) begin
      if (long_step_flag && long_step_release_flag && sequence_counter == LONG_STEP_END_STATE) begin
        long_step_flag <= 1'b0;
        long_step_release_flag <= 1'b0;
      end else if (!long_step_flag && sequence_counter == LONG_STEP_SET_STATE) begin
        long_step_flag <= 1'b1;
      end else if (long_step_flag && next_state == RELEASE_ENTRY_STATE) begin
        long_step_release_flag <= 1'b1;
      end
    end
  end

  // Lines are registered, so each state not gated by a long step shows two cycles after the step that reached it.
  // one-hot decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      command_lines <= '0;
      print_pulse_gate <= 1'b0;
    end else begin
      command_lines <= decoder_enable ? decode_state(sequence_counter) : '0;
      print_pulse_gate <= decoder_enable &&
        (sequence_counter == PRINT_FIRST_STATE || sequence_counter == PRINT_SECOND_STATE);
    end
  end

  assign command = '{command_lines: command_lines, data_update: long_step_flag, print_command: print_pulse_gate};
  assign status = '{state: sequence_counter, measure_phase: measure_phase_flag,
    long_step: long_step_flag, long_step_release: long_step_release_flag};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_step_advance: assert property (step |=> sequence_counter == 4'($past(sequence_counter) + 4'h1))
    else $error("counter did not advance by one");

  a_onehot_lines: assert property ((command_lines != '0) |->
    command_lines == decode_state($past(sequence_counter)))
    else $error("command lines do not match state");

  a_reset_start: assert property (seq_reset |=> sequence_counter == SEQ_START_STATE && !long_step_flag)
    else $error("reset did not return to state zero");

  a_disable_blank: assert property ((step || seq_reset) |=> command_lines == '0)
    else $error("commands active during step or reset");

  a_phase_track: assert property (measure_phase_flag == (sequence_counter <= LAST_MEASURE_STATE))
    else $error("phase flag disagrees with state");

  a_cond_ignored: assert property ((cond_reset_req && !measure_phase_flag && !seq_reset && !step)
    |=> $stable(sequence_counter))
    else $error("conditional reset acted after measuring phase");

  a_long_set: assert property ((step && !long_step_flag && sequence_counter == LONG_STEP_SET_STATE)
    |=> long_step_flag && sequence_counter == LONG_STEP_END_STATE ##1 command_lines == '0)
    else $error("long step not set or not gating");

  a_long_rate: assert property ((seq_clk_pulse && long_step_flag && !seq_reset)
    |=> sequence_counter == 4'($past(sequence_counter) + 4'h1))
    else $error("long step stalled");

  a_release_set: assert property ((step && long_step_flag && !long_step_release_flag &&
    next_state == RELEASE_ENTRY_STATE) |=> long_step_release_flag ##1
    (command_lines != '0 || $past(step) || $past(seq_reset)))
    else $error("release flag not set on entry to eight");

  a_long_clear: assert property ((step && long_step_release_flag && sequence_counter == LONG_STEP_END_STATE)
    |=> !long_step_flag && !long_step_release_flag)
    else $error("long step flags not cleared");

  a_print_or: assert property (print_pulse_gate == (command_lines[PRINT_FIRST_STATE] |
    command_lines[PRINT_SECOND_STATE]))
    else $error("print command mismatch");

  a_freeze_clock: assert property ((!seq_clk_pulse && !seq_reset) |=> $stable(sequence_counter))
    else $error("state moved without a clock pulse");

  a_hold_external: assert property ((seq_clk_pulse && !long_step_flag && remote_programming_option &&
    external_hold && !seq_reset) |=> $stable(sequence_counter))
    else $error("external hold ignored");

  a_hard_reset: assert property (hard_reset_req |=> count_chain_reset [*8] ##0 sequence_counter == SEQ_START_STATE)
    else $error("hard reset pulse missing");

  c_long_release: cover property (long_step_flag && long_step_release_flag && step);
  c_print_pulse: cover property (print_pulse_gate);
  c_cond_reset: cover property (cond_reset_req && measure_phase_flag && sequence_counter != SEQ_START_STATE);
  c_wrap: cover property (step && sequence_counter == 4'hf && !long_step_flag);

endmodule : measurement_sequence_generator

`default_nettype wire

// ===== tb/seq_clock_source.sv
// Model of the counter logic that feeds sequence clock pulses to the sequencer.
`timescale 1ns/1ps
`default_nettype none
module seq_clock_source (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Burst request
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic [7:0] gap,
  // Pulses
  output logic seq_clk_pulse,
  output logic busy
);
  logic [7:0] remain;
  logic [7:0] phase;
  assign busy = (remain != 8'h00) || seq_clk_pulse;
  // paced pulses
  // A real rate of 100 kHz would take 2000 cycles a step, so the bench sets a short gap.
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 8'h00;
      phase <= 8'h00;
      seq_clk_pulse <= 1'b0;
    end else if (load) begin
      remain <= count;
      phase <= 8'h00;
      seq_clk_pulse <= 1'b0;
    end else if (remain != 8'h00 && phase == gap) begin
      remain <= remain - 8'h01;
      phase <= 8'h00;
      seq_clk_pulse <= 1'b1;
    end else begin
      phase <= (remain != 8'h00) ? phase + 8'h01 : 8'h00;
      seq_clk_pulse <= 1'b0;
    end
  end
endmodule : seq_clock_source
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the measurement sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sequencer_pkg::*;
  logic core_clk;
  logic rst_n;
  logic seq_clk_pulse;
  logic internal_hold;
  logic external_hold;
  logic remote_programming_option;
  logic seq_reset_req;
  logic cond_reset_req;
  logic hard_reset_req;
  logic load;
  logic [7:0] count;
  logic [7:0] gap;
  logic busy;
  seq_command_type command;
  seq_status_type status;
  logic count_chain_reset;
  logic converter_reset;
  int errors;
  int compares;
  measurement_sequence_generator u_dut (.core_clk(core_clk), .rst_n(rst_n), .seq_clk_pulse(seq_clk_pulse),
    .internal_hold(internal_hold), .external_hold(external_hold),
    .remote_programming_option(remote_programming_option), .seq_reset_req(seq_reset_req),
    .cond_reset_req(cond_reset_req), .hard_reset_req(hard_reset_req), .command(command), .status(status),
    .count_chain_reset(count_chain_reset), .converter_reset(converter_reset));
  seq_clock_source u_src (.core_clk(core_clk), .rst_n(rst_n), .load(load), .count(count), .gap(gap),
    .seq_clk_pulse(seq_clk_pulse), .busy(busy));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Asks the partner for n pulses and waits until the new line has settled.
  task automatic steps(input int n, input int g);
    @(negedge core_clk);
    load <= 1'b1;
    count <= 8'(n);
    gap <= 8'(g);
    @(negedge core_clk);
    load <= 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < 4000 && busy === 1'b1; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask : steps
  task automatic cond_pulse;
    cond_reset_req <= 1'b1;
    @(negedge core_clk);
    cond_reset_req <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : cond_pulse
  task automatic test_walk;
    for (int s = 1; s <= 11; s++) begin
      steps(1, 3);
      check("state", 16'(status.state), 16'(s));
      check("lines", command.command_lines, 16'h0001 << s);
      check("phase", 16'(status.measure_phase), 16'(s <= 9));
    end
    steps(1, 3);
    check("update", 16'(command.data_update), 16'h0001);
    check("gated", command.command_lines, 16'h0000);
    internal_hold <= 1'b1;
    steps(12, 0);
    check("long state", 16'(status.state), 16'h0008);
    check("release", command.command_lines, 16'h0100);
    steps(4, 0);
    check("second", command.command_lines, 16'h1000);
    internal_hold <= 1'b0;
    steps(1, 2);
    check("flags", 16'({status.long_step, status.long_step_release}), 16'h0000);
    check("print", 16'(command.print_command), 16'h0001);
    steps(1, 2);
    check("print", 16'(command.print_command), 16'h0001);
    steps(1, 2);
    check("print", 16'(command.print_command), 16'h0000);
    steps(1, 2);
    check("wrap", command.command_lines, 16'h0001);
    $display("test walk done");
  endtask : test_walk
  task automatic test_hold_reset;
    internal_hold <= 1'b1;
    steps(3, 1);
    check("frozen", 16'(status.state), 16'h0000);
    internal_hold <= 1'b0;
    external_hold <= 1'b1;
    steps(1, 1);
    check("no option", 16'(status.state), 16'h0001);
    remote_programming_option <= 1'b1;
    steps(2, 1);
    check("held", 16'(status.state), 16'h0001);
    external_hold <= 1'b0;
    steps(2, 1);
    cond_pulse();
    check("cond", 16'(status.state), 16'h0000);
    steps(10, 1);
    cond_pulse();
    check("late cond", 16'(status.state), 16'h000a);
    seq_reset_req <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("blank", command.command_lines, 16'h0000);
    seq_reset_req <= 1'b0;
    repeat (3) @(negedge core_clk);
    check("restart", command.command_lines, 16'h0001);
    $display("test hold and reset done");
  endtask : test_hold_reset
  task automatic test_hard_reset;
    int n;
    steps(5, 1);
    hard_reset_req <= 1'b1;
    @(negedge core_clk);
    hard_reset_req <= 1'b0;
    check("converter", 16'(converter_reset), 16'h0001);
    check("before reset", 16'(status.state), 16'h0005);
    @(negedge core_clk);
    n = 1;
    check("hard state", 16'(status.state), 16'h0000);
    while (count_chain_reset === 1'b1 && n < 1100) begin
      n++;
      @(negedge core_clk);
    end
    check("pulse width", 16'(n), 16'(RESET_PULSE_CYCLES));
    $display("test hard reset done");
  endtask : test_hard_reset
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    {internal_hold, external_hold, remote_programming_option} = 3'h0;
    {seq_reset_req, cond_reset_req, hard_reset_req, load} = 4'h0;
    count = 8'h00;
    gap = 8'h00;
    repeat (20) @(negedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 1100 && count_chain_reset !== 1'b0; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    check("start", command.command_lines, 16'h0001);
    test_walk();
    test_hold_reset();
    test_hard_reset();
    stop_test();
  end
endmodule : tb
`default_nettype wire
